// ===== asp_pkg.sv
`default_nettype none

package asp_pkg;

   // Pin and word geometry
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int CNT_W = 8;

   // Board clock
   localparam int CLK_PERIOD_NS = 100;

   // Slowest speed grade, so one build serves both grades
   localparam int ACCESS_NS = 70;
   localparam int WRITE_PULSE_NS = 50;
   localparam int SELECT_TO_END_NS = 60;
   localparam int DATA_OVERLAP_NS = 30;
   localparam int READ_CYCLE_NS = 70;
   localparam int ADDRESS_LEAD_NS = 0;

   // Least times round up, never below one cycle
   function automatic int ns_to_cycles(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_cycles

   function automatic int max2(input int a, input int b);
      return (a > b) ? a : b;
   endfunction : max2

   // Derived cycle counts
   localparam int ACCESS_CYC = ns_to_cycles(ACCESS_NS);
   localparam int PULSE_CYC = max2(max2(ns_to_cycles(WRITE_PULSE_NS),
      ns_to_cycles(SELECT_TO_END_NS)), ns_to_cycles(DATA_OVERLAP_NS));
   localparam int RECOVER_CYC = ns_to_cycles(READ_CYCLE_NS);

   // Pin levels after reset: low select and strobes inactive, high select active, bus released
   localparam logic PIN_RESET_N = 1'b1;
   localparam logic SEL_HIGH_RESET = 1'b1;
   localparam logic BUS_OE_RESET = 1'b0;

   typedef enum logic [2:0] {
      ASP_IDLE,
      ASP_WR_SETUP,
      ASP_WR_PULSE,
      ASP_WR_END,
      ASP_RD_WAIT,
      ASP_RETAIN,
      ASP_RECOVER
   } asp_state_e;

endpackage : asp_pkg

`default_nettype wire

// ===== asp_timer_if.sv
`timescale 1ns/10ps
`default_nettype none

interface asp_timer_if #(parameter int CNT_W = asp_pkg::CNT_W);
   logic start;
   logic [CNT_W-1:0] load;
   logic busy;
   logic done;

   // Sequencer side
   modport ctl (output start, output load, input busy, input done);
   // Counter side
   modport tmr (input start, input load, output busy, output done);
endinterface : asp_timer_if

`default_nettype wire

// ===== asp_timer.sv
`timescale 1ns/10ps
`default_nettype none

module asp_timer #(
   parameter int CNT_W = asp_pkg::CNT_W
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Sequencer link
   asp_timer_if.tmr tif
);

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] load_seen_reg;
   logic [CNT_W-1:0] age_reg;

   // Down counter; a fresh start always overrides a running count
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= '0;
      end else if (tif.start) begin
         cnt_reg <= tif.load;
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   // Done pulses when the count runs out, never on a restart edge
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tif.done <= 1'b0;
      end else begin
         tif.done <= (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1}) && !tif.start;
      end
   end

   assign tif.busy = (cnt_reg != '0);

   // Helper: cycles since the last start; done lands one past the load
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         load_seen_reg <= '0;
         age_reg <= '0;
      end else if (tif.start) begin
         load_seen_reg <= tif.load;
         age_reg <= {{(CNT_W-1){1'b0}}, 1'b1};
      end else if (age_reg != '1) begin
         age_reg <= age_reg + 1'b1;
      end
   end

   done_after_load_a: assert property (@(posedge mclk) disable iff (!resetn)
      tif.done |-> age_reg == load_seen_reg + 1'b1)
      else $error("timer done came at the wrong count");

endmodule : asp_timer

`default_nettype wire

// ===== asp_host.sv
// Contract
// R1: Word memory of 262,144 sixteen-bit locations.
// R2: Device is static, needs no clock.
// R3: Device floats shared bus unless reading.
// R4: Any deselect puts device in standby.
// R5: Read drives lanes whose select is low.
// R6: Lane selects gate low and high bytes.
// R7: Write stores selected lanes, ignores output enable.
// R8: Both enables high floats both lanes.
// R9: Write needs selects, write enable, lane overlap.
// R10: Write starts at last qualifying edge.
// R11: Write ends at first deasserting edge.
// R12: Hold write overlap for minimum pulse width.
// R13: Address valid before write, held through.
// R14: Selects active long enough before write end.
// R15: Allow write recovery before next cycle.
// R16: Sample read data after access time only.
// R17: Device turn-off beats turn-on, no contention.
// R18: High select gates all other input buffers.
// R19: Retention: hold high select at solid level.
// R20: Wait one read cycle after retention.
// R21: Contents survive standby; aborted writes corrupt.
`timescale 1ns/10ps
`default_nettype none

module asp_host #(
   parameter int ADDR_W = asp_pkg::ADDR_W,
   parameter int DATA_W = asp_pkg::DATA_W
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Request port
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic [1:0] req_byte_en,
   output logic req_ready,
   // Answer port
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   // Retention control
   input wire logic retain_req,
   output logic retained,
   // Memory pins
   output logic [ADDR_W-1:0] word_address,
   output logic select_low_active,
   output logic select_high_active,
   output logic write_enable_n,
   output logic output_enable_n,
   output logic low_lane_select_n,
   output logic high_lane_select_n,
   // Shared data bus, split into its three parts
   input wire logic [DATA_W-1:0] shared_data_bus_in,
   output logic [DATA_W-1:0] shared_data_bus_out,
   output logic shared_data_bus_oe
);

   localparam int HALF = DATA_W / 2;

   asp_pkg::asp_state_e state_reg;
   asp_pkg::asp_state_e state_next;
   logic [1:0] be_reg;
   logic [1:0] be_cur;
   logic write_reg;
   logic accept;
   logic in_access;
   logic [7:0] we_low_cnt;
   logic [7:0] oe_low_cnt;
   logic [7:0] wake_cnt;

   asp_timer_if #(.CNT_W(asp_pkg::CNT_W)) tif ();

   asp_timer #(.CNT_W(asp_pkg::CNT_W)) u_timer (
      .mclk(mclk),
      .resetn(resetn),
      .tif(tif)
   );

   // Lane pins from byte enables: enable bit set drives select low
   function automatic logic [1:0] lane_n(input logic [1:0] be);
      return ~be;
   endfunction : lane_n

   // Read data keeps only the lanes that were selected
   function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] be);
      return {{HALF{be[1]}}, {HALF{be[0]}}};
   endfunction : lane_mask

   assign accept = req_valid && req_ready && (state_reg == asp_pkg::ASP_IDLE);
   assign be_cur = accept ? req_byte_en : be_reg;
   assign in_access = state_next inside {asp_pkg::ASP_WR_SETUP, asp_pkg::ASP_WR_PULSE,
      asp_pkg::ASP_WR_END, asp_pkg::ASP_RD_WAIT};

   // Sequencer; a request offered while req_ready is high wins over retention
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         asp_pkg::ASP_IDLE: begin
            if (accept) begin
               state_next = req_write ? asp_pkg::ASP_WR_SETUP : asp_pkg::ASP_RD_WAIT;
            end else if (retain_req) begin
               state_next = asp_pkg::ASP_RETAIN;
            end
         end
         asp_pkg::ASP_WR_SETUP: state_next = asp_pkg::ASP_WR_PULSE; // R13
         asp_pkg::ASP_WR_PULSE: begin
            if (tif.done) begin
               state_next = asp_pkg::ASP_WR_END; // R12
            end
         end
         asp_pkg::ASP_WR_END: state_next = asp_pkg::ASP_IDLE; // R15
         asp_pkg::ASP_RD_WAIT: begin
            if (tif.done) begin
               state_next = asp_pkg::ASP_IDLE; // R16
            end
         end
         asp_pkg::ASP_RETAIN: begin
            if (!retain_req) begin
               state_next = asp_pkg::ASP_RECOVER;
            end
         end
         asp_pkg::ASP_RECOVER: begin
            if (tif.done) begin
               state_next = asp_pkg::ASP_IDLE; // R20
            end
         end
      endcase
   end

   // Timer load on entry to each timed phase
   always_comb begin
      tif.start = (state_next != state_reg) && (state_next inside {asp_pkg::ASP_WR_PULSE,
         asp_pkg::ASP_RD_WAIT, asp_pkg::ASP_RECOVER});
      unique case (state_next)
         asp_pkg::ASP_WR_PULSE: tif.load = asp_pkg::CNT_W'(asp_pkg::PULSE_CYC); // R12 R14
         asp_pkg::ASP_RD_WAIT: tif.load = asp_pkg::CNT_W'(asp_pkg::ACCESS_CYC); // R16
         asp_pkg::ASP_RECOVER: tif.load = asp_pkg::CNT_W'(asp_pkg::RECOVER_CYC); // R20
         default: tif.load = '0;
      endcase
   end

   // State and handshake
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= asp_pkg::ASP_IDLE;
         req_ready <= 1'b0;
         retained <= 1'b0;
      end else begin
         state_reg <= state_next;
         req_ready <= (state_next == asp_pkg::ASP_IDLE);
         retained <= state_next inside {asp_pkg::ASP_RETAIN, asp_pkg::ASP_RECOVER};
      end
   end

   // Request capture; address holds until the next request
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         word_address <= '0;
         shared_data_bus_out <= '0;
         be_reg <= '0;
         write_reg <= 1'b0;
      end else if (accept) begin
         word_address <= req_addr; // R13
         shared_data_bus_out <= req_wdata;
         be_reg <= req_byte_en;
         write_reg <= req_write;
      end
   end

   // Control pins. Address and selects settle a cycle before write
   // enable falls, so write enable is always the last qualifying edge
   // and also the first to release.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         select_low_active <= asp_pkg::PIN_RESET_N;
         select_high_active <= asp_pkg::SEL_HIGH_RESET;
         write_enable_n <= asp_pkg::PIN_RESET_N;
         output_enable_n <= asp_pkg::PIN_RESET_N;
         low_lane_select_n <= asp_pkg::PIN_RESET_N;
         high_lane_select_n <= asp_pkg::PIN_RESET_N;
      end else begin
         select_low_active <= !in_access; // R14
         select_high_active <= (state_next != asp_pkg::ASP_RETAIN); // R19
         write_enable_n <= (state_next != asp_pkg::ASP_WR_PULSE); // R12
         output_enable_n <= (state_next != asp_pkg::ASP_RD_WAIT);
         {high_lane_select_n, low_lane_select_n} <= in_access ? lane_n(be_cur) : 2'b11;
      end
   end

   // Bus drive only while output enable is high, so the memory's
   // outputs are off; the read-to-write gap is at least an idle cycle and a whole setup cycle.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         shared_data_bus_oe <= asp_pkg::BUS_OE_RESET;
      end else begin
         shared_data_bus_oe <= state_next inside {asp_pkg::ASP_WR_PULSE,
            asp_pkg::ASP_WR_END}; // R17
      end
   end

   // Answer: one pulse per finished access
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         rsp_valid <= (state_reg == asp_pkg::ASP_WR_END) ||
            ((state_reg == asp_pkg::ASP_RD_WAIT) && tif.done);
         if ((state_reg == asp_pkg::ASP_RD_WAIT) && tif.done) begin
            rsp_rdata <= shared_data_bus_in & lane_mask(be_reg); // R16
         end
      end
   end

   // Helper counters for the checks below
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         we_low_cnt <= '0;
         oe_low_cnt <= '0;
         wake_cnt <= 8'hff;
      end else begin
         we_low_cnt <= write_enable_n ? 8'h00 : ((we_low_cnt == 8'hff) ? we_low_cnt :
            we_low_cnt + 8'h01);
         oe_low_cnt <= output_enable_n ? 8'h00 : ((oe_low_cnt == 8'hff) ? oe_low_cnt :
            oe_low_cnt + 8'h01);
         wake_cnt <= !select_high_active ? 8'h00 : ((wake_cnt == 8'hff) ? wake_cnt :
            wake_cnt + 8'h01);
      end
   end

   wr_pulse_width_a: assert property (@(posedge mclk) disable iff (!resetn) // R12
      $rose(write_enable_n) |-> we_low_cnt >= 8'(asp_pkg::PULSE_CYC))
      else $error("write pulse shorter than minimum");

   addr_held_a: assert property (@(posedge mclk) disable iff (!resetn) // R13
      (!write_enable_n || $rose(write_enable_n)) |-> $stable(word_address))
      else $error("address moved during write");

   select_overlap_a: assert property (@(posedge mclk) disable iff (!resetn) // R14
      !write_enable_n |-> (!select_low_active && select_high_active &&
      $past(!select_low_active)))
      else $error("selects not active through write");

   wr_recovery_a: assert property (@(posedge mclk) disable iff (!resetn) // R15
      $rose(write_enable_n) |-> !select_low_active ##1 select_low_active)
      else $error("write end not followed by recovery");

   rd_access_a: assert property (@(posedge mclk) disable iff (!resetn) // R16
      (state_reg == asp_pkg::ASP_RD_WAIT && tif.done) |->
      (oe_low_cnt >= 8'(asp_pkg::ACCESS_CYC) && $stable(word_address)))
      else $error("read sampled before access time");

   no_contention_a: assert property (@(posedge mclk) disable iff (!resetn) // R17
      shared_data_bus_oe |-> (output_enable_n && $past(output_enable_n)))
      else $error("bus driven while memory may drive");

   retain_solid_a: assert property (@(posedge mclk) disable iff (!resetn) // R19
      (state_reg == asp_pkg::ASP_RETAIN) |-> (!select_high_active && select_low_active))
      else $error("retention levels not solid");

   wake_wait_a: assert property (@(posedge mclk) disable iff (!resetn) // R20
      accept |-> wake_cnt > 8'(asp_pkg::RECOVER_CYC))
      else $error("access too soon after retention");

   // A stale count would shorten the next timed phase
   timer_idle_a: assert property (@(posedge mclk) disable iff (!resetn) // R15
      (state_reg == asp_pkg::ASP_IDLE) |-> !tif.busy)
      else $error("timer still running while idle");

   write_only_a: assert property (@(posedge mclk) disable iff (!resetn) // R12
      !write_enable_n |-> write_reg)
      else $error("write enable low outside a write");

endmodule : asp_host

`default_nettype wire

// ===== asp_sram_model.sv
`timescale 1ns/10ps
`default_nettype none

module asp_sram_model (
   // Memory pins from the host
   input wire logic [asp_pkg::ADDR_W-1:0] word_address,
   input wire logic select_low_active,
   input wire logic select_high_active,
   input wire logic write_enable_n,
   input wire logic output_enable_n,
   input wire logic low_lane_select_n,
   input wire logic high_lane_select_n,
   // Host side of the shared bus
   input wire logic [asp_pkg::DATA_W-1:0] host_data,
   input wire logic host_oe,
   // Resolved bus and device drive
   output logic [asp_pkg::DATA_W-1:0] bus_level,
   output logic [asp_pkg::DATA_W-1:0] dev_drive,
   // Host timing faults seen
   output int viol
);
   logic [asp_pkg::DATA_W-1:0] mem [0:(2**asp_pkg::ADDR_W)-1];
   logic [asp_pkg::DATA_W-1:0] last_q = 16'h0000;
   logic [asp_pkg::DATA_W-1:0] wr_data, wr_lanes, lanes, dev_val, drv, val;
   logic sel, wr_act, rd_ok;
   realtime t_wr = -1.0;
   realtime t_sel = 0.0;
   realtime t_wake = 0.0;

   // Decode; the high select gates every other input
   assign sel = !select_low_active && select_high_active;
   assign lanes = {{8{!high_lane_select_n}}, {8{!low_lane_select_n}}};
   assign wr_act = sel && !write_enable_n && (lanes != 16'h0000);
   // Zero-delay turn-off, so never later than turn-on
   assign dev_drive = (sel && write_enable_n && !output_enable_n) ? lanes : 16'h0000;
   // Garbage until access time has run out
   assign dev_val = rd_ok ? mem[word_address] : ~mem[word_address];
   assign drv = dev_drive | {16{host_oe}};
   assign val = (dev_drive & dev_val) | (~dev_drive & host_data);
   // Released lines show the inverse of their last value, no keeper
   assign bus_level = (drv & val) | (~drv & ~last_q);
   always @(drv or val) last_q = (drv & val) | (~drv & last_q);

   // Read data not valid before access time
   always @(word_address or dev_drive) begin
      rd_ok = 1'b0;
      rd_ok <= #(asp_pkg::ACCESS_NS) 1'b1;
   end

   // Write starts at the last qualifying edge
   always @(posedge wr_act) t_wr = $realtime;
   always @* if (wr_act) begin
      wr_data = val;
      wr_lanes = lanes;
   end
   always @(negedge select_low_active or posedge select_high_active) t_sel = $realtime;

   // Store at the first deasserting edge; a short pulse corrupts
   always @(negedge wr_act) begin
      if (t_wr >= 0.0) begin
         if ($realtime - t_wr < asp_pkg::WRITE_PULSE_NS) begin
            viol++;
            mem[word_address] = 'x;
         end else begin
            mem[word_address] = (wr_lanes & wr_data) | (~wr_lanes & mem[word_address]);
         end
         if ($realtime - t_sel < asp_pkg::SELECT_TO_END_NS) viol++;
      end
      t_wr = -1.0;
   end

   // Host faults: moving address, bus fight, early wake, floating select
   always @(word_address) if (wr_act) viol++;
   always @(dev_drive or host_oe) if (host_oe && dev_drive != 16'h0000) viol++;
   always @(posedge select_high_active) t_wake = $realtime;
   always @(negedge select_low_active) begin
      if (t_wake > 0.0 && $realtime - t_wake < asp_pkg::READ_CYCLE_NS) viol++;
   end
   always @(select_high_active) if (select_high_active !== 1'b0 && select_high_active !== 1'b1) viol++;
endmodule : asp_sram_model

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
   typedef struct {logic w; logic [17:0] a; logic [15:0] d; logic [1:0] be; logic [15:0] q;} asp_row_s;
   logic mclk, resetn, req_valid, req_write, req_ready, rsp_valid, retain_req, retained;
   logic [17:0] req_addr, word_address;
   logic [15:0] req_wdata, rsp_rdata, bus_in, bus_out, dev_drive, q;
   logic [1:0] req_byte_en;
   logic sel_lo, sel_hi, we_n, oe_n, lo_lane_n, hi_lane_n, bus_oe;
   int bad_count, n_checks, viol, lat;
   // Ordinary cases: write, lane write, empty lane set, boundary address
   asp_row_s rows [11] = '{
      '{1'b1, 18'h00000, 16'ha5c3, 2'h3, 16'h0000}, '{1'b0, 18'h00000, 16'h0000, 2'h3, 16'ha5c3},
      '{1'b1, 18'h00000, 16'hff7e, 2'h1, 16'h0000}, '{1'b0, 18'h00000, 16'h0000, 2'h3, 16'ha57e},
      '{1'b1, 18'h3ffff, 16'h1234, 2'h3, 16'h0000}, '{1'b1, 18'h3ffff, 16'h99aa, 2'h2, 16'h0000},
      '{1'b0, 18'h3ffff, 16'h0000, 2'h2, 16'h9900}, '{1'b0, 18'h3ffff, 16'h0000, 2'h1, 16'h0034},
      '{1'b1, 18'h3ffff, 16'hffff, 2'h0, 16'h0000}, '{1'b0, 18'h3ffff, 16'h0000, 2'h3, 16'h9934},
      '{1'b0, 18'h00000, 16'h0000, 2'h0, 16'h0000}};

   asp_host dut (.mclk(mclk), .resetn(resetn), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_byte_en(req_byte_en),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .retain_req(retain_req), .retained(retained), .word_address(word_address),
      .select_low_active(sel_lo), .select_high_active(sel_hi), .write_enable_n(we_n),
      .output_enable_n(oe_n), .low_lane_select_n(lo_lane_n), .high_lane_select_n(hi_lane_n),
      .shared_data_bus_in(bus_in), .shared_data_bus_out(bus_out), .shared_data_bus_oe(bus_oe));

   asp_sram_model mem_model (.word_address(word_address), .select_low_active(sel_lo),
      .select_high_active(sel_hi), .write_enable_n(we_n), .output_enable_n(oe_n),
      .low_lane_select_n(lo_lane_n), .high_lane_select_n(hi_lane_n), .host_data(bus_out),
      .host_oe(bus_oe), .bus_level(bus_in), .dev_drive(dev_drive), .viol(viol));

   // Board clock
   initial begin
      mclk = 1'b0;
      forever #(asp_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   // One request, held until taken; entered just after an edge
   task automatic do_req(input logic w, input logic [17:0] a, input logic [15:0] d,
      input logic [1:0] be, output logic [15:0] rd, output int n);
      int k;
      k = 0;
      req_valid = 1'b1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      req_byte_en = be;
      while (req_ready !== 1'b1 && k < 50) begin
         @(posedge mclk);
         #1;
         k++;
      end
      @(posedge mclk);
      #1;
      req_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 50) begin
         @(posedge mclk);
         #1;
         n++;
      end
      rd = rsp_rdata;
   endtask : do_req

   // Hang guard, well beyond the expected run
   initial begin
      #(3000 * asp_pkg::CLK_PERIOD_NS);
      bad_count++;
      test_done();
   end

   initial begin
      resetn = 1'b0;
      {req_valid, req_write, retain_req} = 3'h0;
      req_addr = 18'h00000;
      req_wdata = 16'h0000;
      req_byte_en = 2'h0;
      bad_count = 0;
      n_checks = 0;
      repeat (2) @(posedge mclk);
      #1;
      // Pins idle during reset: deselected, bus released
      check({8'h00, sel_lo, sel_hi, we_n, oe_n, lo_lane_n, hi_lane_n, bus_oe, req_ready},
         16'h00fc, "reset pins");
      resetn = 1'b1;
      @(posedge mclk);
      #1;
      check(dev_drive, 16'h0000, "standby drive");
      $display("test reset done");
      // Table, back to back; each timed phase runs its count plus one cycle
      foreach (rows[i]) begin
         do_req(rows[i].w, rows[i].a, rows[i].d, rows[i].be, q, lat);
         check(16'(lat), 16'(rows[i].w ? asp_pkg::PULSE_CYC + 3 : asp_pkg::ACCESS_CYC + 1), "latency");
         if (!rows[i].w) check(q, rows[i].q, "read data");
      end
      $display("test table done");
      // Retention through the high select, then wake
      retain_req = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      check({13'h0000, retained, sel_hi, req_ready}, 16'h0004, "retention pins");
      check(dev_drive, 16'h0000, "retention drive");
      retain_req = 1'b0;
      do_req(1'b0, 18'h00000, 16'h0000, 2'h3, q, lat);
      check(q, 16'ha57e, "data after retention");
      $display("test retention done");
      // Reset in mid-run keeps memory; bus floats after the read
      resetn = 1'b0;
      @(posedge mclk);
      #1;
      check({12'h000, retained, rsp_valid, req_ready, bus_oe}, 16'h0000, "mid-run reset");
      resetn = 1'b1;
      @(posedge mclk);
      #1;
      do_req(1'b0, 18'h3ffff, 16'h0000, 2'h3, q, lat);
      check(q, 16'h9934, "data after reset");
      check(bus_in, 16'h66cb, "bus released");
      check(16'(viol), 16'h0000, "host timing");
      $display("test reset and release done");
      test_done();
   end
endmodule : testbench

`default_nettype wire
